// [ssp_pkg.sv]
// Constants and types for the power switch serial command port.
// Assumes a single system clock domain; all pin inputs are asynchronous.
package ssp_pkg;
	localparam int CH_COUNT = 6;
	localparam int CFG_WIDTH = 4;
	localparam int FRAME_BITS = 8;
	// Command byte fields
	localparam int CMD_WRITE_BIT = 7;
	localparam int CMD_BANK_BIT = 6;
	localparam int CMD_PTR_HI = 5;
	localparam int CMD_PTR_LO = 4;
	localparam int CMD_DIAG_BIT = 0;
	// Response byte fields
	localparam int RSP_READ_BIT = 7;
	localparam int RSP_BANK_BIT = 6;
	// Configuration pointer values
	localparam logic [1:0] PTR_PWM_LED = 2'h1;
	localparam logic [1:0] PTR_HW_CTRL = 2'h2;
	localparam logic [1:0] PTR_DIAG_CTRL = 2'h3;
	// Reset values
	localparam logic [5:0] CH_SWITCH_RST = 6'h00;
	localparam logic [3:0] PWM_LED_RST = 4'h0;
	localparam logic [3:0] HW_CTRL_RST = 4'h6;
	localparam logic [3:0] DIAG_CTRL_RST = 4'h7;
	// Writable bits of the mixed registers; bit 3 reads back as zero
	localparam logic [3:0] HW_CTRL_WMASK = 4'h7;
	localparam logic [3:0] DIAG_CTRL_WMASK = 4'h7;
	typedef enum {RSP_DIAG, RSP_CHAN, RSP_CFG} ssp_rsp_t;
endpackage

// [ssp_spi_port.sv]
// Serial command port of a six-channel power switch.
// Assumes csN, sclk, sdi, limpHome and channelFault are asynchronous pins.
// What this block does
// [RULE1] Read takes two frames, result in second
// [RULE2] Read request: bit7 clear, bit0 selects diagnosis
// [RULE3] Read answer: bit7 set, bank, register data
// [RULE4] Command in answer frame also executes
// [RULE5] Error flag driven before first rising clock
// [RULE6] Flag zero after multiple-of-eight clock count
// [RULE7] Flag one after bad count or reset
// [RULE8] Bit6 selects channel or configuration bank
// [RULE9] Write 10 loads six channel bits
// [RULE10] Bits 5:4 point at configuration register
// [RULE11] Write 11 stores bits 3:0 (bits 2:0 for hardware and diagnosis control); read returns them
// [RULE12] Diagnosis: bit7 zero, bit6 limp home level
// [RULE13] Diagnosis fault bit per faulty channel
// [RULE14] Reset restores all register defaults
// [RULE15] Input data sampled on falling clock edge
// [RULE16] Output released while chip select high
// [RULE17] MSB first; bad count frames discarded
// [RULE18] Commands take effect at chip select rise
module ssp_spi_port #(
	parameter int CH_COUNT = ssp_pkg::CH_COUNT,
	parameter int CFG_WIDTH = ssp_pkg::CFG_WIDTH,
	parameter int FRAME_BITS = ssp_pkg::FRAME_BITS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic csN,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic limpHome,
	input wire logic [5:0] channelFault,
	output logic sdo,
	output logic sdoOe,
	output logic [5:0] channelSwitch,
	output logic [3:0] pwmLedCtrl,
	output logic [3:0] hwCtrl,
	output logic [3:0] diagCtrl
);
	typedef struct packed {
		logic [2:0] csSync;
		logic [2:0] clkSync;
		logic [1:0] dataSync;
		logic [1:0] limpSync;
		logic [11:0] faultSync;
		logic [7:0] rxShift;
		logic [7:0] txShift;
		logic [2:0] bitCount;
		logic sawClock;
		logic frameErr;
		ssp_pkg::ssp_rsp_t rspSel;
		logic [1:0] rspPtr;
		logic [5:0] chSwitch;
		logic [3:0] pwmLed;
		logic [3:0] hwReg;
		logic [3:0] diagReg;
		logic sdoVal;
		logic sdoEn;
	} ssp_state_t;

	ssp_state_t st_r;
	ssp_state_t st_nxt;

	logic csLow;
	logic csFall;
	logic csRise;
	logic clkRise;
	logic clkFall;
	logic [7:0] cmd;
	logic [3:0] cfgRead;
	logic [7:0] rspByte;
	logic [7:0] rspChan;
	logic [7:0] rspCfg;
	logic [7:0] rspDiag;
	logic frameOk;
	logic cmdWrite;
	logic cmdCfgBank;
	logic cmdReadReg;
	logic [1:0] cmdPtr;
	logic [3:0] cmdData;
	logic chWrite;
	logic pwmWrite;
	logic hwWrite;
	logic diagWrite;

	// Port widths and the 3-bit frame counter fit one layout only
	if (CH_COUNT != ssp_pkg::CH_COUNT) begin : g_bad_ch
		$error("ssp_spi_port serves six channels only");
	end
	if (CFG_WIDTH != ssp_pkg::CFG_WIDTH) begin : g_bad_cfg
		$error("ssp_spi_port serves four-bit configuration registers only");
	end
	if (FRAME_BITS != ssp_pkg::FRAME_BITS) begin : g_bad_frame
		$error("ssp_spi_port serves eight-bit frames only");
	end

	// Stage 1 of each synchroniser feeds only stage 2
	assign csLow = ~st_r.csSync[1];
	assign csFall = st_r.csSync[2] & ~st_r.csSync[1];
	assign csRise = ~st_r.csSync[2] & st_r.csSync[1];
	assign clkRise = csLow & ~st_r.clkSync[2] & st_r.clkSync[1];
	assign clkFall = csLow & st_r.clkSync[2] & ~st_r.clkSync[1];
	assign cmd = st_r.rxShift;

	// Whole bytes and at least one clock make a valid frame
	assign frameOk = st_r.bitCount == 3'h0 && st_r.sawClock; // [RULE17]
	assign cmdWrite = cmd[ssp_pkg::CMD_WRITE_BIT];
	assign cmdCfgBank = cmd[ssp_pkg::CMD_BANK_BIT]; // [RULE8]
	assign cmdReadReg = ~cmdWrite & ~cmd[ssp_pkg::CMD_DIAG_BIT]; // [RULE2]
	assign cmdPtr = cmd[ssp_pkg::CMD_PTR_HI:ssp_pkg::CMD_PTR_LO]; // [RULE10]
	assign cmdData = cmd[3:0];

	// Write strobes; pointer zero selects nothing
	assign chWrite = frameOk & cmdWrite & ~cmdCfgBank; // [RULE9]
	assign pwmWrite = frameOk & cmdWrite & cmdCfgBank & (cmdPtr == ssp_pkg::PTR_PWM_LED);
	assign hwWrite = frameOk & cmdWrite & cmdCfgBank & (cmdPtr == ssp_pkg::PTR_HW_CTRL);
	assign diagWrite = frameOk & cmdWrite & cmdCfgBank & (cmdPtr == ssp_pkg::PTR_DIAG_CTRL);

	// Answer words, one per kind of pending answer
	assign rspChan = {1'b1, 1'b0, st_r.chSwitch}; // [RULE3]
	assign rspCfg = {1'b1, 1'b1, st_r.rspPtr, cfgRead}; // [RULE3] [RULE11]
	assign rspDiag = {1'b0, st_r.limpSync[1], st_r.faultSync[11:6]}; // [RULE12] [RULE13]

	always_comb begin
		unique case (st_r.rspPtr)
			ssp_pkg::PTR_PWM_LED: cfgRead = st_r.pwmLed;
			ssp_pkg::PTR_HW_CTRL: cfgRead = st_r.hwReg;
			ssp_pkg::PTR_DIAG_CTRL: cfgRead = st_r.diagReg;
			default: cfgRead = 4'h0;
		endcase
	end

	always_comb begin
		unique case (st_r.rspSel)
			ssp_pkg::RSP_CHAN: begin
				rspByte = rspChan;
			end
			ssp_pkg::RSP_CFG: begin
				rspByte = rspCfg;
			end
			ssp_pkg::RSP_DIAG: begin
				rspByte = rspDiag;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.csSync = {st_r.csSync[1:0], csN};
		st_nxt.clkSync = {st_r.clkSync[1:0], sclk};
		st_nxt.dataSync = {st_r.dataSync[0], sdi};
		st_nxt.limpSync = {st_r.limpSync[0], limpHome};
		st_nxt.faultSync = {st_r.faultSync[5:0], channelFault};
		if (csFall) begin
			// Flag shown before any clock, answer queued behind it
			st_nxt.sdoEn = 1'b1; // [RULE16]
			st_nxt.sdoVal = st_r.frameErr; // [RULE5]
			st_nxt.txShift = rspByte; // [RULE1]
			st_nxt.bitCount = 3'h0;
			st_nxt.sawClock = 1'b0;
		end
		if (clkRise) begin
			st_nxt.sdoVal = st_r.txShift[7]; // [RULE17]
			st_nxt.txShift = {st_r.txShift[6:0], 1'b0};
		end
		if (clkFall) begin
			st_nxt.rxShift = {st_r.rxShift[6:0], st_r.dataSync[1]}; // [RULE15] [RULE17]
			st_nxt.bitCount = st_r.bitCount + 3'h1;
			st_nxt.sawClock = 1'b1;
		end
		if (csRise) begin
			st_nxt.sdoEn = 1'b0; // [RULE16]
			st_nxt.sdoVal = 1'b0;
			st_nxt.frameErr = st_r.bitCount != 3'h0; // [RULE6] [RULE7]
			// Writes, diagnosis requests and bad frames leave diagnosis as the next answer
			st_nxt.rspSel = ssp_pkg::RSP_DIAG; // [RULE4]
			if (frameOk) begin
				// Last eight bits form the command
				st_nxt.rspPtr = cmdPtr; // [RULE10]
				if (cmdReadReg) begin
					st_nxt.rspSel = cmdCfgBank ? ssp_pkg::RSP_CFG : ssp_pkg::RSP_CHAN; // [RULE1]
				end
			end
			if (chWrite) begin
				st_nxt.chSwitch = cmd[5:0]; // [RULE9] [RULE18]
			end
			if (pwmWrite) begin
				st_nxt.pwmLed = cmdData; // [RULE11]
			end
			if (hwWrite) begin
				st_nxt.hwReg = cmdData & ssp_pkg::HW_CTRL_WMASK; // [RULE11]
			end
			if (diagWrite) begin
				st_nxt.diagReg = cmdData & ssp_pkg::DIAG_CTRL_WMASK; // [RULE11]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= '0;
			st_r.csSync <= 3'h7;
			st_r.frameErr <= 1'b1; // [RULE7]
			st_r.rspSel <= ssp_pkg::RSP_DIAG;
			st_r.chSwitch <= ssp_pkg::CH_SWITCH_RST; // [RULE14]
			st_r.pwmLed <= ssp_pkg::PWM_LED_RST;
			st_r.hwReg <= ssp_pkg::HW_CTRL_RST;
			st_r.diagReg <= ssp_pkg::DIAG_CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sdo = st_r.sdoVal;
	assign sdoOe = st_r.sdoEn;
	assign channelSwitch = st_r.chSwitch;
	assign pwmLedCtrl = st_r.pwmLed;
	assign hwCtrl = st_r.hwReg;
	assign diagCtrl = st_r.diagReg;
endmodule

// [ssp_props.sv]
// Checker of pin timing and register updates of the serial port.
// Assumes a bind onto ssp_spi_port, one clock domain.
module ssp_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic csN,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdoOe,
	input wire logic [5:0] channelSwitch,
	input wire logic [3:0] pwmLedCtrl,
	input wire logic [3:0] hwCtrl,
	input wire logic [3:0] diagCtrl
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic [17:0] regs = {channelSwitch, pwmLedCtrl, hwCtrl, diagCtrl};
	a_oe_on: assert property ($fell(csN) |-> ##[2:5] sdoOe) else $error("sdo not on");
	a_oe_off: assert property ($rose(csN) |-> ##[2:5] !sdoOe) else $error("sdo not off");
	a_oe_idle: assert property (csN [*6] |-> !sdoOe) else $error("sdo on while idle");
	a_oe_busy: assert property (!csN [*6] |-> sdoOe) else $error("sdo off in frame");
	a_sdo_low: assert property (!sdoOe |-> !sdo) else $error("sdo high when off");
	a_sdo_hold: assert property ((!csN && $stable(sclk)) [*7] |=> $stable(sdo)) else $error("sdo moved");
	a_regs_frame: assert property (!csN [*6] |=> $stable(regs)) else $error("reg in frame");
	a_bit3_zero: assert property (!hwCtrl[3] && !diagCtrl[3]) else $error("bit3 set");
	a_reset_vals: assert property (disable iff (1'b0) reset |=> regs == 18'h00067) else $error("bad reset");
	cover property ($rose(csN));
	cover property ($changed(channelSwitch));
	cover property ($changed(pwmLedCtrl));
endmodule

// [ssp_master.sv]
// Host side serial master, one frame per call.
// Assumes 4 ns clk; sclk 160 ns, low and sdi pulled low outside frames.
module ssp_master (
	input wire logic clk,
	output logic csN,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx, output logic er);
		csN <= 1'b0;
		repeat (250) @(posedge clk);
		er = sdo;
		for (int i = 0; i < n; i++) begin
			sdi <= tx[7 - i];
			sclk <= 1'b1;
			repeat (20) @(posedge clk);
			rx = {rx[6:0], sdo};
			sclk <= 1'b0;
			repeat (20) @(posedge clk);
		end
		repeat (250) @(posedge clk);
		csN <= 1'b1;
		sdi <= 1'b0;
		repeat (250) @(posedge clk);
	endtask
endmodule

// [smart_switch_spi_command_port_bench.sv]
// Bench: table of command frames, then a bad count and a second reset.
// Assumes ssp_master on the pins and ssp_props bound to the port.
module smart_switch_spi_command_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic csN, sclk, sdi, sdo, sdoOe, er;
	logic [5:0] channelSwitch;
	logic [3:0] pwmLedCtrl, hwCtrl, diagCtrl;
	logic [7:0] rx;
	logic limpHome = 1'b1;
	logic [5:0] channelFault = 6'h25;
	int n_mismatch = 0;
	int checks = 0;
	// Command sent, answer to the previous row's command expected in the same frame
	logic [15:0] rows [12] = '{16'haa65, 16'h0065, 16'hd9aa, 16'h5065, 16'hefd9, 16'h6065,
		16'h01e7, 16'h7065, 16'h41f7, 16'hf565, 16'hcf65, 16'h4065};
	ssp_spi_port i_ssp_spi_port (.clk(clk), .reset(reset), .csN(csN), .sclk(sclk), .sdi(sdi),
		.limpHome(limpHome), .channelFault(channelFault), .sdo(sdo), .sdoOe(sdoOe),
		.channelSwitch(channelSwitch), .pwmLedCtrl(pwmLedCtrl), .hwCtrl(hwCtrl), .diagCtrl(diagCtrl));
	ssp_master i_ssp_master (.clk(clk), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			i_ssp_master.xfer(rows[i][15:8], 8, rx, er);
			chk(rx, rows[i][7:0]);
			chk({7'h0, er}, {7'h0, i == 0});
			$display("row %0d done", i);
		end
		chk({2'h0, channelSwitch}, 8'h2a);
		chk({pwmLedCtrl, hwCtrl}, 8'h97);
		chk({diagCtrl, 4'h0}, 8'h50);
		i_ssp_master.xfer(8'h00, 8, rx, er);
		chk(rx, 8'hc0);
		i_ssp_master.xfer(8'h80, 7, rx, er);
		i_ssp_master.xfer(8'h00, 8, rx, er);
		chk({er, rx[6:0]}, 8'he5);
		i_ssp_master.xfer(8'h00, 8, rx, er);
		chk({er, 1'b0, channelSwitch}, 8'h2a);
		chk(rx, 8'haa);
		$display("bad count done");
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		chk({2'h0, channelSwitch}, 8'h00);
		chk({pwmLedCtrl, hwCtrl}, 8'h06);
		chk({diagCtrl, 3'h0, sdoOe}, 8'h70);
		i_ssp_master.xfer(8'h00, 8, rx, er);
		chk({er, rx[6:0]}, 8'he5);
		$display("reset done");
		limpHome <= 1'b0;
		channelFault <= 6'h1a;
		i_ssp_master.xfer(8'h01, 8, rx, er);
		chk(rx, 8'h80);
		i_ssp_master.xfer(8'h00, 8, rx, er);
		chk(rx, 8'h1a);
		$display("diagnosis pins done");
		end_sim();
	end
endmodule
bind ssp_spi_port ssp_props i_ssp_props (.clk(clk), .reset(reset), .csN(csN), .sclk(sclk),
	.sdo(sdo), .sdoOe(sdoOe), .channelSwitch(channelSwitch), .pwmLedCtrl(pwmLedCtrl),
	.hwCtrl(hwCtrl), .diagCtrl(diagCtrl));
